/* hdl/lrb_burst_ctrl.sv */
// Function
// - back-to-back reads join at length 4, cut off at lengths 8 and 16
// - random reads every tick to open rows; each new read interrupts the last
// - burst stop ends a read burst and leaves the row open
// - precharge two ticks after a read still lets two pairs out
// - read with auto precharge closes the row half a burst later
// - narrow mode, lower strobe times lower byte, upper strobe upper byte
// - wide mode, strobe n times byte lane n
// - write captures bank, column, auto precharge; precharges after the burst
// - byte stored when its mask is low, left alone when high
// - first element on first rising strobe edge, then every strobe edge
// - write done after postamble plus recovery or write-to-read interval
// - after a write burst, further input data is ignored
// - a new write may follow any tick, chaining or cutting the last
// - read cuts a write; only pairs captured before it are stored
// - recovery intervals count from first rising tick after the last pair
// - burst stop acts after read latency; output ends right there
`timescale 1ns/1ps
module lrb_burst_ctrl #(
    parameter int WR_TICKS = lrb_pkg::WRITE_RECOVERY_TICKS,
    parameter int WTR_TICKS = lrb_pkg::WRITE_TO_READ_TICKS,
    parameter int RAS_TICKS = lrb_pkg::ROW_ACTIVE_TICKS,
    parameter int FIFO_DEPTH = lrb_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic [2:0] cmdPins,
    input wire logic [lrb_pkg::BANK_W-1:0] cmdBank,
    input wire logic [lrb_pkg::COL_W-1:0] cmdCol,
    input wire logic cmdAutoPre,
    input wire logic wide32,
    input wire logic [1:0] burstLength,
    input wire logic [2:0] readLatency,
    input wire logic [lrb_pkg::DATA_W-1:0] dqIn,
    input wire logic [lrb_pkg::LANES-1:0] writeByteMask,
    input wire logic [lrb_pkg::LANES-1:0] wrStrobeIn,
    output logic [lrb_pkg::DATA_W-1:0] dqOut,
    output logic dqOe,
    output logic [lrb_pkg::LANES-1:0] rdStrobeOut,
    output logic rdStrobeOe,
    output logic [lrb_pkg::BANK_W-1:0] arrRdBank,
    output logic [lrb_pkg::COL_W-1:0] arrRdCol,
    input wire logic [lrb_pkg::DATA_W-1:0] arrRdData,
    output logic arrWrValid,
    input wire logic arrWrReady,
    output logic [lrb_pkg::BANK_W-1:0] arrWrBank,
    output logic [lrb_pkg::COL_W-1:0] arrWrCol,
    output logic [lrb_pkg::DATA_W-1:0] arrWrData,
    output logic [lrb_pkg::LANES-1:0] arrWrByteEn,
    output logic [lrb_pkg::BANKS-1:0] prechargeStart,
    output logic [lrb_pkg::BANKS-1:0] bankOpen,
    output logic readBusy,
    output logic writeBusy,
    output logic writeToReadMet
);
    import lrb_pkg::*;

    localparam int SYNC_W = 1 + 3 + BANK_W + COL_W + 1 + LANES + DATA_W + LANES;
    localparam logic [TICK_W-1:0] WR_T = TICK_W'(WR_TICKS);
    localparam logic [TICK_W-1:0] WTR_T = TICK_W'(WTR_TICKS);
    localparam logic [TICK_W-1:0] RAS_T = TICK_W'(RAS_TICKS);

    typedef enum logic [1:0] {WR_IDLE, WR_DATA, WR_RECOVER} lrb_wr_state_t;

    function automatic logic [COL_W-1:0] colOf(input logic [COL_W-1:0] base,
                                               input logic [4:0] idx,
                                               input logic [4:0] len);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] s;
        m = COL_W'(len - 5'h01);
        s = base + COL_W'(idx);
        colOf = (base & ~m) | (s & m);
    endfunction

    // ------------------------------------------------------------------
    // pin synchroniser and edge finders
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic ckPrev_q;
    logic [LANES-1:0] stbPrev_q;
    logic sCk;
    logic [2:0] sCmd;
    logic [BANK_W-1:0] sBank;
    logic [COL_W-1:0] sCol;
    logic sAp;
    logic [LANES-1:0] sStb;
    logic [DATA_W-1:0] sDq;
    logic [LANES-1:0] sMask;

    // two stages before anything looks at the pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= '0;
            syncB_q <= '0;
            ckPrev_q <= 1'b0;
            stbPrev_q <= '0;
        end else if (clkEn) begin
            syncA_q <= {linkClk, cmdPins, cmdBank, cmdCol, cmdAutoPre,
                        wrStrobeIn, dqIn, writeByteMask};
            syncB_q <= syncA_q;
            ckPrev_q <= sCk;
            stbPrev_q <= sStb;
        end
    end

    // unpack the settled pins and find link and strobe edges
    assign {sCk, sCmd, sBank, sCol, sAp, sStb, sDq, sMask} = syncB_q;
    wire ckRise = sCk & ~ckPrev_q;
    wire ckEdge = sCk ^ ckPrev_q;
    wire [LANES-1:0] stbRise = sStb & ~stbPrev_q;
    wire [LANES-1:0] stbEdge = sStb ^ stbPrev_q;

    // ------------------------------------------------------------------
    // command decode on each rising link tick
    // ------------------------------------------------------------------
    wire lrb_cmd_t cmdNow = lrb_cmd_t'(sCmd);
    wire isAct = ckRise & (cmdNow == CMD_ACTIVE);
    wire isRead = ckRise & (cmdNow == CMD_READ);
    wire isWrite = ckRise & (cmdNow == CMD_WRITE);
    wire isPre = ckRise & (cmdNow == CMD_PRECHARGE);
    wire isStop = ckRise & (cmdNow == CMD_BURST_STOP);
    wire [4:0] blElems = BURST_BASE << burstLength;
    wire [4:0] blHalf = blElems >> 1;
    wire [2:0] tapSel = readLatency - 3'h1;
    logic [BANK_W-1:0] rdCmdBank_q;
    // precharge to the bank being read cuts the burst like a stop
    wire preCuts = isPre & (sAp | (sBank == rdCmdBank_q));

    // ------------------------------------------------------------------
    // read latency pipeline
    // ------------------------------------------------------------------
    logic pipeValid_q [LAT_MAX];
    logic pipeStop_q [LAT_MAX];
    logic [BANK_W-1:0] pipeBank_q [LAT_MAX];
    logic [COL_W-1:0] pipeCol_q [LAT_MAX];

    // stops travel the same pipe as reads, same latency
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < LAT_MAX; i++) begin
                pipeValid_q[i] <= 1'b0;
                pipeStop_q[i] <= 1'b0;
                pipeBank_q[i] <= BANK_RESET;
                pipeCol_q[i] <= COL_RESET;
            end
            rdCmdBank_q <= BANK_RESET;
        end else if (clkEn && ckRise) begin
            pipeValid_q[0] <= isRead | isStop | preCuts;
            pipeStop_q[0] <= isStop | preCuts;
            pipeBank_q[0] <= sBank;
            pipeCol_q[0] <= sCol;
            for (int i = 1; i < LAT_MAX; i++) begin
                pipeValid_q[i] <= pipeValid_q[i-1];
                pipeStop_q[i] <= pipeStop_q[i-1];
                pipeBank_q[i] <= pipeBank_q[i-1];
                pipeCol_q[i] <= pipeCol_q[i-1];
            end
            if (isRead) begin
                rdCmdBank_q <= sBank;
            end
        end
    end

    // entry reaching the latency tap acts on this tick
    wire tapValid = pipeValid_q[tapSel];
    wire tapStop = pipeStop_q[tapSel];
    wire startNow = ckRise & tapValid & ~tapStop;
    // a stop only silences the output, bank state is not touched
    wire stopNow = ckRise & tapValid & tapStop;

    // ------------------------------------------------------------------
    // read burst engine, one element per link edge
    // ------------------------------------------------------------------
    logic [4:0] rdLeft_q;
    logic [4:0] rdIdx_q;
    logic [4:0] rdLen_q;
    logic [COL_W-1:0] rdBase_q;
    logic emitPend_q;
    logic edgePend_q;
    logic oddPend_q;
    wire moreNow = ckEdge & ~stopNow & (rdLeft_q != COUNT_RESET);
    wire emitNow = startNow | moreNow;

    // a start at the tap always reloads, so 4 joins and 8/16 cut
    // new read interrupts whatever burst is running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdLeft_q <= COUNT_RESET;
            rdIdx_q <= COUNT_RESET;
            rdLen_q <= BURST_BASE;
            rdBase_q <= COL_RESET;
            arrRdBank <= BANK_RESET;
            arrRdCol <= COL_RESET;
        end else if (clkEn) begin
            if (startNow) begin
                rdLeft_q <= blElems - 5'h01;
                rdIdx_q <= 5'h01;
                rdLen_q <= blElems;
                rdBase_q <= pipeCol_q[tapSel];
                arrRdBank <= pipeBank_q[tapSel];
                arrRdCol <= pipeCol_q[tapSel];
            end else if (stopNow) begin
                rdLeft_q <= COUNT_RESET;
            end else if (moreNow) begin
                rdLeft_q <= rdLeft_q - 5'h01;
                rdIdx_q <= rdIdx_q + 5'h01;
                arrRdCol <= colOf(rdBase_q, rdIdx_q, rdLen_q);
            end
        end
    end

    // array answers one clock after the address; drive pins then
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            emitPend_q <= 1'b0;
            edgePend_q <= 1'b0;
            oddPend_q <= 1'b0;
            dqOut <= DATA_RESET;
            dqOe <= 1'b0;
            rdStrobeOut <= '0;
        end else if (clkEn) begin
            emitPend_q <= emitNow;
            edgePend_q <= ckEdge;
            oddPend_q <= startNow ? 1'b0 : rdIdx_q[0];
            if (edgePend_q) begin
                dqOe <= emitPend_q;
                rdStrobeOut <= {LANES{emitPend_q & ~oddPend_q}};
                if (emitPend_q) begin
                    dqOut <= arrRdData;
                end
            end
        end
    end

    assign rdStrobeOe = dqOe;
    assign readBusy = (rdLeft_q != COUNT_RESET) | dqOe;

    // ------------------------------------------------------------------
    // write capture engine
    // ------------------------------------------------------------------
    lrb_wr_state_t wrState_q;
    logic [BANK_W-1:0] wrBank_q;
    logic [COL_W-1:0] wrBase_q;
    logic wrAp_q;
    logic [4:0] wrIdx_q;
    logic [4:0] wrLeft_q;
    logic [4:0] wrLen_q;
    logic [TICK_W-1:0] recElapsed_q;
    logic [LANES-1:0] laneGot_q;
    logic [LANES-1:0] laneRose_q;
    logic [LANES-1:0] laneMask_q;
    logic [DATA_W-1:0] laneData_q;
    logic wrApFire;
    lrb_fifo_if #(.WIDTH(WR_WORD_W)) wrq ();

    // narrow mode uses lanes 0 and 1 only
    wire [LANES-1:0] laneOn = wide32 ? 4'hF : 4'h3;
    wire inData = (wrState_q == WR_DATA);
    // first element needs a rising edge, then any edge
    wire [LANES-1:0] laneEdge = (laneRose_q & stbEdge) | (~laneRose_q & stbRise);
    // outside a burst nothing is captured
    wire [LANES-1:0] laneCap = {LANES{inData}} & laneOn & ~laneGot_q & laneEdge;
    wire elemFull = inData & ((laneGot_q & laneOn) == laneOn);
    wire elemPush = elemFull & wrq.inReady;
    wire lastElem = elemPush & (wrLeft_q == 5'h01);
    wire recDone = (wrState_q == WR_RECOVER) & ckRise & (recElapsed_q >= WR_T);

    // each lane latches on its own strobe
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_lane
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    laneData_q[l*LANE_W +: LANE_W] <= '0;
                    laneMask_q[l] <= 1'b0;
                end else if (clkEn && laneCap[l]) begin
                    laneData_q[l*LANE_W +: LANE_W] <= sDq[l*LANE_W +: LANE_W];
                    laneMask_q[l] <= sMask[l];
                end
            end
        end
    endgenerate

    // lane flags: capture sets, a push clears laneGot_q of all lanes at once, laneRose_q stays set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            laneGot_q <= '0;
            laneRose_q <= '0;
        end else if (clkEn) begin
            if (isWrite && !inData) begin
                laneGot_q <= '0;
                laneRose_q <= '0;
            end else begin
                laneGot_q <= (elemPush ? '0 : laneGot_q) | laneCap;
                laneRose_q <= laneRose_q | laneCap;
            end
        end
    end

    // burst state, chaining and truncation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrState_q <= WR_IDLE;
            wrBank_q <= BANK_RESET;
            wrBase_q <= COL_RESET;
            wrAp_q <= 1'b0;
            wrIdx_q <= COUNT_RESET;
            wrLeft_q <= COUNT_RESET;
            wrLen_q <= BURST_BASE;
            recElapsed_q <= '0;
        end else if (clkEn) begin
            // command fields kept for the whole burst
            // a new write restarts the burst at its own column
            if (isWrite) begin
                wrState_q <= WR_DATA;
                wrBank_q <= sBank;
                wrBase_q <= sCol;
                wrAp_q <= sAp;
                wrIdx_q <= COUNT_RESET;
                wrLeft_q <= blElems;
                wrLen_q <= blElems;
            // read drops everything not yet captured
            end else if (isRead && inData) begin
                wrState_q <= WR_IDLE;
            end else begin
                case (wrState_q)
                    WR_DATA: begin
                        if (elemPush) begin
                            wrIdx_q <= wrIdx_q + 5'h01;
                            wrLeft_q <= wrLeft_q - 5'h01;
                        end
                        if (lastElem) begin
                            wrState_q <= WR_RECOVER;
                            recElapsed_q <= '0;
                        end
                    end
                    WR_RECOVER: begin
                        // first rise after the last pair is the reference
                        if (recDone) begin
                            wrState_q <= WR_IDLE;
                        end else if (ckRise) begin
                            recElapsed_q <= recElapsed_q + 1'b1;
                        end
                    end
                    default: begin
                        wrState_q <= WR_IDLE;
                    end
                endcase
            end
        end
    end

    // auto precharge once recovery is over
    assign wrApFire = recDone & wrAp_q & ~isWrite;
    // busy through data, postamble and recovery
    assign writeBusy = (wrState_q != WR_IDLE);
    assign writeToReadMet = (wrState_q == WR_IDLE) |
                            ((wrState_q == WR_RECOVER) & (recElapsed_q > WTR_T));

    // ------------------------------------------------------------------
    // write queue toward the array
    // ------------------------------------------------------------------
    assign wrq.inValid = elemFull;
    assign wrq.inData = {wrBank_q, colOf(wrBase_q, wrIdx_q, wrLen_q),
                         laneData_q, laneMask_q};
    assign wrq.outReady = arrWrReady;

    lrb_fifo #(
        .WIDTH(WR_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wrq (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .port(wrq.fifo)
    );

    // a high mask bit disables that byte's write
    assign arrWrValid = wrq.outValid;
    assign {arrWrBank, arrWrCol, arrWrData} = wrq.outData[WR_WORD_W-1:LANES];
    assign arrWrByteEn = ~wrq.outData[LANES-1:0] & laneOn;

    // ------------------------------------------------------------------
    // per-bank row state and precharge scheduling
    // ------------------------------------------------------------------
    // each bank keeps its own open flag and timers
    generate
        for (genvar b = 0; b < BANKS; b++) begin : g_bank
            logic [TICK_W-1:0] rasCnt_q;
            logic [4:0] apCnt_q;
            logic apPend_q;
            wire hit = (sBank == BANK_W'(b));
            wire rasOk = (rasCnt_q >= RAS_T);
            // read auto precharge fires half a burst after the read
            wire rdApFire = ckRise & apPend_q & (apCnt_q <= 5'h01) & rasOk;
            wire expFire = isPre & (sAp | hit) & bankOpen[b];
            wire wrFire = wrApFire & (wrBank_q == BANK_W'(b));
            wire fire = rdApFire | expFire | wrFire;
            wire apSet = isRead & sAp & hit;

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    bankOpen[b] <= 1'b0;
                    prechargeStart[b] <= 1'b0;
                    rasCnt_q <= '0;
                    apCnt_q <= COUNT_RESET;
                    apPend_q <= 1'b0;
                end else if (clkEn) begin
                    prechargeStart[b] <= fire;
                    if (isAct && hit) begin
                        bankOpen[b] <= 1'b1;
                        rasCnt_q <= '0;
                    end else if (fire) begin
                        bankOpen[b] <= 1'b0;
                    end else if (ckRise && !rasOk) begin
                        rasCnt_q <= rasCnt_q + 1'b1;
                    end
                    if (apSet) begin
                        apPend_q <= 1'b1;
                        apCnt_q <= blHalf;
                    end else if (fire) begin
                        apPend_q <= 1'b0;
                    end else if (ckRise && apCnt_q > 5'h01) begin
                        apCnt_q <= apCnt_q - 5'h01;
                    end
                end
            end
        end
    endgenerate
endmodule

/* shared/lrb_pkg.sv */
package lrb_pkg;
    // --------------------------------------------------------------
    // geometry
    // --------------------------------------------------------------
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int COL_W = 10;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int LAT_MAX = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int WR_WORD_W = BANK_W + COL_W + DATA_W + LANES;

    // --------------------------------------------------------------
    // command codes on the command pins
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_BURST_STOP
    } lrb_cmd_t;

    // burst length select codes
    localparam logic [1:0] BURST_LEN_2 = 2'h0;
    localparam logic [1:0] BURST_LEN_4 = 2'h1;
    localparam logic [1:0] BURST_LEN_8 = 2'h2;
    localparam logic [1:0] BURST_LEN_16 = 2'h3;
    localparam logic [4:0] BURST_BASE = 5'h02;

    // --------------------------------------------------------------
    // timing, clock periods in ns, intervals in link clock periods
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 64;
    localparam int WRITE_RECOVERY_TICKS = 2;
    localparam int WRITE_TO_READ_TICKS = 1;
    localparam int ROW_ACTIVE_TICKS = 6;
    localparam int TICK_W = 4;

    // --------------------------------------------------------------
    // values after reset
    // --------------------------------------------------------------
    localparam logic [COL_W-1:0] COL_RESET = 10'h000;
    localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [4:0] COUNT_RESET = 5'h00;
endpackage

/* shared/lrb_fifo_if.sv */
`timescale 1ns/1ps
interface lrb_fifo_if #(
    parameter int WIDTH = 8
);
    logic inValid;
    logic inReady;
    logic [WIDTH-1:0] inData;
    logic outValid;
    logic outReady;
    logic [WIDTH-1:0] outData;

    // storage side
    modport fifo (
        input inValid,
        input inData,
        input outReady,
        output inReady,
        output outValid,
        output outData
    );

    // producer and consumer side
    modport user (
        output inValid,
        output inData,
        output outReady,
        input inReady,
        input outValid,
        input outData
    );
endinterface

/* hdl/lrb_fifo.sv */
`timescale 1ns/1ps
module lrb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    lrb_fifo_if.fifo port
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;
    wire push = port.inValid & port.inReady;
    wire pop = port.outValid & port.outReady;

    // --------------------------------------------------------------
    // flags and head word
    // --------------------------------------------------------------
    assign port.inReady = (count_q != FULL_CNT);
    assign port.outValid = (count_q != '0);
    assign port.outData = mem[rdPtr_q];

    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr_q] <= port.inData;
        end
    end

    // pointers wrap at the last slot
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (clkEn) begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

/* verification/lrb_burst_ctrl_assertions.sv */
`timescale 1ns/1ps
module lrb_burst_ctrl_assertions (
    input logic clk, rst_b, clkEn, wide32, dqOe, rdStrobeOe,
    input logic readBusy, writeBusy, writeToReadMet, arrWrValid,
    input logic [31:0] dqOut,
    input logic [3:0] rdStrobeOut, arrWrByteEn, prechargeStart, bankOpen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_strobe_oe_tie: assert property (rdStrobeOe == dqOe)
        else $error("strobe oe apart");
    a_first_strobe: assert property ($rose(dqOe) |-> rdStrobeOut[1:0] == 2'h3)
        else $error("first strobe low");
    a_read_pair: assert property ($rose(dqOe) |=> dqOe)
        else $error("lone element");
    a_idle_wtr: assert property (!writeBusy |-> writeToReadMet)
        else $error("idle blocks read");
    a_pre_pulse: assert property (|prechargeStart |=> prechargeStart == 4'h0)
        else $error("long precharge");
    a_pre_open: assert property
        ((prechargeStart & ~($past(bankOpen) | $past(bankOpen, 2))) == 4'h0)
        else $error("closed bank precharge");
    a_freeze_all: assert property (!clkEn |=> $stable(dqOut) && $stable(bankOpen))
        else $error("moved while frozen");
    a_x16_lanes: assert property (!wide32 && arrWrValid |-> arrWrByteEn[3:2] == 2'h0)
        else $error("upper lanes on");
    c_read: cover property ($rose(dqOe));
    c_pre: cover property (|prechargeStart);
    c_narrow: cover property (arrWrValid && !wide32);
endmodule

/* verification/lrb_ctrl_model.sv */
`timescale 1ns/1ps
module lrb_ctrl_model (
    output logic linkClk, ap,
    output logic [2:0] cmd,
    output logic [1:0] bank,
    output logic [9:0] col,
    output logic [31:0] dq,
    output logic [3:0] dm, dqs
);
    import lrb_pkg::*;
    // free link clock, phase apart from clk
    initial begin
        {linkClk, ap, cmd, bank, col, dq, dm, dqs} = '0;
        #3;
        forever #32 linkClk = ~linkClk;
    end
    // one command per tick, set at the falling edge
    task automatic issue(lrb_cmd_t c, int b, int k, bit a);
        @(negedge linkClk);
        cmd <= c;
        bank <= 2'(b);
        col <= 10'(k);
        ap <= a;
    endtask
    task automatic burst(int n, logic [3:0] m);
        @(posedge linkClk);
        #48;
        for (int k = 0; k < n; k++) begin
            dq <= 32'hA500_0000 + k;
            dm <= m;
            #16 dqs <= k[0] ? 4'h0 : 4'hF;
            #16;
        end
        dq <= ~dq;
    endtask
endmodule

/* verification/lrb_burst_ctrl_bench.sv */
`timescale 1ns/1ps
module lrb_burst_ctrl_bench;
    import lrb_pkg::*;
    logic clk = 0, rst_b = 0, clkEn = 0, wide32 = 1, ready = 0, lk, ap, dqOe, wValid;
    logic [1:0] bl = 1, bank, wBank, rBank;
    logic [2:0] cmd;
    logic [9:0] col, wCol, rCol;
    logic [31:0] dq, dqOut, wData, rdData, got[$];
    logic [3:0] dm, dqs, be, open;
    int n_errors = 0, n_tests = 0;
    assign rdData = {20'hC0DE0, rBank, rCol};
    lrb_ctrl_model ctl (.linkClk(lk), .ap(ap), .cmd(cmd), .bank(bank), .col(col),
        .dq(dq), .dm(dm), .dqs(dqs));
    lrb_burst_ctrl #(.RAS_TICKS(1)) uut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
        .linkClk(lk), .cmdPins(cmd), .cmdBank(bank), .cmdCol(col), .cmdAutoPre(ap),
        .wide32(wide32), .burstLength(bl), .readLatency(3'h2), .dqIn(dq),
        .writeByteMask(dm), .wrStrobeIn(dqs), .dqOut(dqOut), .dqOe(dqOe),
        .rdStrobeOut(), .rdStrobeOe(), .arrRdBank(rBank), .arrRdCol(rCol),
        .arrRdData(rdData), .arrWrValid(wValid), .arrWrReady(ready), .arrWrBank(wBank),
        .arrWrCol(wCol), .arrWrData(wData), .arrWrByteEn(be), .prechargeStart(),
        .bankOpen(open), .readBusy(), .writeBusy(), .writeToReadMet());
    initial forever #4 clk = ~clk;
    // collect each new read element
    always @(posedge clk)
        if (dqOe === 1 && (got.size() == 0 || dqOut !== got[$])) got.push_back(dqOut);
    task automatic check(string s, logic [31:0] e, logic [31:0] v);
        n_tests++;
        if (v !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic t_read;
        ctl.issue(CMD_ACTIVE, 1, 0, 0);
        got = {};
        ctl.issue(CMD_READ, 1, 5, 0);
        ctl.issue(CMD_NOP, 0, 0, 0);
        ctl.issue(CMD_READ, 1, 8, 1);
        repeat (7) ctl.issue(CMD_NOP, 0, 0, 0);
        check("count", 8, got.size());
        check("wrap", {20'hC0DE0, 12'h404}, got[3]);
        check("tail", {20'hC0DE0, 12'h40B}, got[7]);
        check("auto pre", 0, open[1]);
    endtask
    task automatic t_cut(lrb_cmd_t c, int gap, int n);
        @(posedge clk) bl <= BURST_LEN_8;
        ctl.issue(CMD_ACTIVE, 1, 0, 0);
        got = {};
        ctl.issue(CMD_READ, 1, 0, 0);
        repeat (gap - 1) ctl.issue(CMD_NOP, 0, 0, 0);
        ctl.issue(c, 1, 0, 0);
        repeat (7) ctl.issue(CMD_NOP, 0, 0, 0);
        check("cut", n, got.size());
        check("open", c == CMD_BURST_STOP, open[1]);
    endtask
    task automatic t_write(bit w, int b, logic [1:0] len, int n, logic [3:0] m, en);
        int k;
        int t;
        logic [31:0] lm;
        lm = {{16{w}}, 16'hFFFF};
        @(posedge clk) wide32 <= w;
        bl <= len;
        ready <= 0;
        ctl.issue(CMD_ACTIVE, b, 0, 0);
        ctl.issue(CMD_WRITE, b, 3, 1);
        fork
            ctl.burst(n, m);
            ctl.issue(CMD_NOP, 0, 0, 0);
        join
        repeat (4) ctl.issue(CMD_NOP, 0, 0, 0);
        check("wr pre", 0, open[b]);
        k = 0;
        @(posedge clk) ready <= 1;
        for (t = 0; t < 99; t++) begin
            @(posedge clk);
            if (wValid === 1) begin
                check("col", (3 & ~(n - 1)) + (3 + k) % n, wCol);
                check("data", (32'hA500_0000 + k) & lm, wData & lm);
                check("lanes", {2'(b), en}, {wBank, be});
                k++;
            end
        end
        check("words", n, k);
    endtask
    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        clkEn <= 1;
        check("reset", 0, {dqOe, wValid, open});
        t_read;
        t_cut(CMD_BURST_STOP, 1, 2);
        t_cut(CMD_PRECHARGE, 2, 4);
        t_write(1, 2, BURST_LEN_16, 16, 4'h2, 4'hD);
        t_write(0, 3, BURST_LEN_2, 2, 4'h0, 4'h3);
        report_and_stop;
    end
endmodule
bind lrb_burst_ctrl lrb_burst_ctrl_assertions chk (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .wide32(wide32), .dqOe(dqOe), .rdStrobeOe(rdStrobeOe), .readBusy(readBusy),
    .writeBusy(writeBusy), .writeToReadMet(writeToReadMet), .arrWrValid(arrWrValid),
    .dqOut(dqOut), .rdStrobeOut(rdStrobeOut), .arrWrByteEn(arrWrByteEn),
    .prechargeStart(prechargeStart), .bankOpen(bankOpen));
